// File: include/frpc_pkg.sv
package frpc_pkg;

	// ----------------------------------------
	// Bus and register map
	// ----------------------------------------
	localparam int APB_AW = 18;
	localparam int NUM_CH = 3;
	localparam logic [15:0] IDX_COUNTER = 16'hFF60;
	localparam logic [15:0] IDX_CAP_A = 16'hFF61;
	localparam logic [15:0] IDX_CAP_B = 16'hFF62;
	localparam logic [15:0] IDX_CAP_C = 16'hFF63;
	localparam logic [15:0] IDX_MODE = 16'hFF65;
	localparam logic [15:0] IDX_CFG = 16'hFF66;
	localparam logic [15:0] IDX_STATUS = 16'hFF68;
	localparam logic [15:0] IDX_MASK = 16'hFF69;
	localparam logic [APB_AW-1:0] ADDR_COUNTER = {IDX_COUNTER, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_CAP_A = {IDX_CAP_A, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_CAP_B = {IDX_CAP_B, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_CAP_C = {IDX_CAP_C, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_CFG = {IDX_CFG, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [APB_AW-1:0] ADDR_MASK = {IDX_MASK, 2'b00};

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CFG_DIV_LSB = 0;
	localparam int CFG_EDGE_A_LSB = 2;
	localparam int CFG_EDGE_B_LSB = 4;
	localparam int CFG_EDGE_C_LSB = 6;
	localparam int MODE_RUN_BIT = 2;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [15:0] COUNTER_RESET = 16'h0000;

	// ----------------------------------------
	// Edge codes and divide ratios
	// ----------------------------------------
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BAD = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [7:0] DIV_RATIO_0 = 8'h04;
	localparam logic [7:0] DIV_RATIO_1 = 8'h08;
	localparam logic [7:0] DIV_RATIO_2 = 8'h20;
	localparam logic [7:0] DIV_RATIO_3 = 8'h80;

endpackage

// File: src/frpc_prescale.sv
`timescale 1ns/1ns
module frpc_prescale import frpc_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic [1:0] div_sel,
	// Count clock pulse
	output logic tick
);

	logic [7:0] div_cnt_reg;
	logic [7:0] div_cnt_next;
	logic [7:0] ratio;

	always_comb begin
		unique case (div_sel)
			2'h0: ratio = DIV_RATIO_0;
			2'h1: ratio = DIV_RATIO_1;
			2'h2: ratio = DIV_RATIO_2;
			2'h3: ratio = DIV_RATIO_3;
		endcase
		tick = run && (div_cnt_reg == ratio - 8'h01);
		// Held at zero while stopped, so start-up lag stays under one period
		if (!run || tick) begin
			div_cnt_next = 8'h00;
		end else begin
			div_cnt_next = div_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= 8'h00;
		end else begin
			div_cnt_reg <= div_cnt_next;
		end
	end

endmodule

// File: src/frpc_edge_det.sv
`timescale 1ns/1ns
module frpc_edge_det (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sampling control
	input wire logic run,
	input wire logic tick,
	// Raw pin
	input wire logic pin,
	// Filtered edge pulses
	output logic rise,
	output logic fall
);

	logic sync1_reg;
	logic sync2_reg;
	logic samp_reg;
	logic samp_next;
	logic lvl_reg;
	logic lvl_next;
	logic agree;

	always_comb begin
		agree = run && tick && (samp_reg == sync2_reg) && (sync2_reg != lvl_reg);
		rise = agree && sync2_reg;
		fall = agree && !sync2_reg;
		samp_next = samp_reg;
		lvl_next = lvl_reg;
		// Stopped: forget the level, so a high pin shows a rise at restart
		if (!run) begin
			samp_next = 1'b0;
			lvl_next = 1'b0;
		end else if (tick) begin
			samp_next = sync2_reg;
			if (agree) begin
				lvl_next = sync2_reg;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			samp_reg <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			sync1_reg <= pin;
			sync2_reg <= sync1_reg;
			samp_reg <= samp_next;
			lvl_reg <= lvl_next;
		end
	end

endmodule

// File: src/frpc_top.sv
// Register access over APB was decided locally.
`timescale 1ns/1ns
// Function
// - Channel c edge field, bits 6-7: 00 fall, 01 rise, 11 both, 10 none.
// - Channel b edge field, bits 4-5: 00 fall, 01 rise, 11 both, 10 none.
// - Channel a edge field, bits 2-3: 00 fall, 01 rise, 11 both, 10 none.
// - Low two bits pick count clock: system clock over 4, 8, 32, 128.
// - Counter runs freely; captures never clear or reload it.
// - Valid edge on input a copies counter into capture a, raises request.
// - Valid edge on input b copies counter into capture b, raises request.
// - Valid edge on input c copies counter into capture c, raises request.
// - Inputs sampled at count clock; edge valid after two equal new samples.
// - Counting may start up to one count period after enable.
// - Capture and request still happen while software reads that capture register.
// - Enabling with input high and rise or both selected raises request.
// - Counter value is undefined while stopped.
// - Read-only counter increments each count clock, reset to zero.
// - Mode bit 2 enables counting, zero stops; reset value zero.
// - Capture registers read as one 16-bit access, undefined after reset.
module frpc_top import frpc_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Capture pins
	input wire logic capture_input_a,
	input wire logic capture_input_b,
	input wire logic capture_input_c,
	// Interrupt
	output logic irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] capture_prescaler_edge_config_reg;
	logic [7:0] capture_prescaler_edge_config_next;
	logic [7:0] counter_mode_control_reg;
	logic [7:0] counter_mode_control_next;
	logic [15:0] free_run_counter_reg;
	logic [15:0] free_run_counter_next;
	logic [15:0] cap_reg [NUM_CH];
	logic [15:0] cap_next [NUM_CH];
	logic [NUM_CH-1:0] status_reg;
	logic [NUM_CH-1:0] status_next;
	logic [NUM_CH-1:0] mask_reg;
	logic [NUM_CH-1:0] mask_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic irq_reg;
	logic irq_next;

	logic counter_run_enable;
	logic tick;
	logic [NUM_CH-1:0] pins;
	logic [NUM_CH-1:0] rise;
	logic [NUM_CH-1:0] fall;
	logic [NUM_CH-1:0] qual;
	logic [1:0] edge_code [NUM_CH];
	logic setup;
	logic done;
	logic wr_done;
	logic rd_status_done;
	logic mapped;

	assign counter_run_enable = counter_mode_control_reg[MODE_RUN_BIT];
	assign pins = {capture_input_c, capture_input_b, capture_input_a};
	assign edge_code[0] = capture_prescaler_edge_config_reg[CFG_EDGE_A_LSB +: 2];
	assign edge_code[1] = capture_prescaler_edge_config_reg[CFG_EDGE_B_LSB +: 2];
	assign edge_code[2] = capture_prescaler_edge_config_reg[CFG_EDGE_C_LSB +: 2];

	// ----------------------------------------
	// Count clock
	// ----------------------------------------
	// Divider restarts at enable; first tick lags it by one cycle short of a count period
	frpc_prescale u_prescale (
		.pclk(pclk),
		.presetn(presetn),
		.run(counter_run_enable),
		.div_sel(capture_prescaler_edge_config_reg[CFG_DIV_LSB +: 2]),
		.tick(tick)
	);

	// ----------------------------------------
	// Input filters and edge qualification
	// ----------------------------------------
	generate
		for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
			frpc_edge_det u_edge (
				.pclk(pclk),
				.presetn(presetn),
				.run(counter_run_enable),
				.tick(tick),
				.pin(pins[ch]),
				.rise(rise[ch]),
				.fall(fall[ch])
			);
			// Prohibited code captures nothing
			always_comb begin
				unique case (edge_code[ch])
					EDGE_FALL: qual[ch] = fall[ch];
					EDGE_RISE: qual[ch] = rise[ch];
					EDGE_BAD: qual[ch] = 1'b0;
					EDGE_BOTH: qual[ch] = rise[ch] || fall[ch];
				endcase
			end
		end
	endgenerate

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	always_comb begin
		setup = psel && !penable;
		done = psel && penable && pready_reg;
		wr_done = done && pwrite && !pslverr_reg;
		rd_status_done = done && !pwrite && (paddr == ADDR_STATUS);
		unique case (paddr)
			ADDR_COUNTER, ADDR_CAP_A, ADDR_CAP_B, ADDR_CAP_C: mapped = 1'b1;
			ADDR_MODE, ADDR_CFG, ADDR_STATUS, ADDR_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Counter, captures and interrupt status
	// ----------------------------------------
	always_comb begin
		capture_prescaler_edge_config_next = capture_prescaler_edge_config_reg;
		counter_mode_control_next = counter_mode_control_reg;
		mask_next = mask_reg;
		if (wr_done && paddr == ADDR_CFG) begin
			capture_prescaler_edge_config_next = pwdata[7:0];
		end
		if (wr_done && paddr == ADDR_MODE) begin
			counter_mode_control_next = '0;
			counter_mode_control_next[MODE_RUN_BIT] = pwdata[MODE_RUN_BIT];
		end
		if (wr_done && paddr == ADDR_MASK) begin
			mask_next = pwdata[NUM_CH-1:0];
		end
		// Stopped counter just holds; software must treat it as undefined
		free_run_counter_next = free_run_counter_reg;
		if (counter_run_enable && tick) begin
			free_run_counter_next = free_run_counter_reg + 16'h0001;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			cap_next[i] = qual[i] ? free_run_counter_reg : cap_reg[i];
		end
		// Clear only the bits that read reported; new sets win
		status_next = status_reg;
		if (rd_status_done) begin
			status_next = status_reg & ~prdata_reg[NUM_CH-1:0];
		end
		status_next = status_next | qual;
		irq_next = |(status_next & mask_next);
	end

	// ----------------------------------------
	// Read data, registered in the setup phase
	// ----------------------------------------
	always_comb begin
		prdata_next = prdata_reg;
		pready_next = setup;
		pslverr_next = setup && !mapped;
		if (setup) begin
			prdata_next = 32'h0000_0000;
			if (!pwrite) begin
				unique case (paddr)
					ADDR_COUNTER: prdata_next[15:0] = free_run_counter_reg;
					ADDR_CAP_A: prdata_next[15:0] = cap_reg[0];
					ADDR_CAP_B: prdata_next[15:0] = cap_reg[1];
					ADDR_CAP_C: prdata_next[15:0] = cap_reg[2];
					ADDR_MODE: prdata_next[7:0] = counter_mode_control_reg;
					ADDR_CFG: prdata_next[7:0] = capture_prescaler_edge_config_reg;
					ADDR_STATUS: prdata_next[NUM_CH-1:0] = status_reg;
					ADDR_MASK: prdata_next[NUM_CH-1:0] = mask_reg;
					default: prdata_next = 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_prescaler_edge_config_reg <= CFG_RESET;
			counter_mode_control_reg <= MODE_RESET;
			mask_reg <= MASK_RESET;
			free_run_counter_reg <= COUNTER_RESET;
			status_reg <= '0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			capture_prescaler_edge_config_reg <= capture_prescaler_edge_config_next;
			counter_mode_control_reg <= counter_mode_control_next;
			mask_reg <= mask_next;
			free_run_counter_reg <= free_run_counter_next;
			status_reg <= status_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
		end
	end

	// Capture contents carry no reset
	always_ff @(posedge pclk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			cap_reg[i] <= cap_next[i];
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [1:0] div_sel;
	assign div_sel = capture_prescaler_edge_config_reg[CFG_DIV_LSB +: 2];

	sequence s_gap4;
		(!tick)[*3] ##1 (tick || !counter_run_enable);
	endsequence

	sequence s_gap8;
		(!tick)[*7] ##1 (tick || !counter_run_enable);
	endsequence

	a_div_four_gap: assert property (
		tick && div_sel == 2'h0 && $stable(div_sel) |-> ##1 s_gap4
	) else $error("count clock not system clock over 4");

	a_div_eight_gap: assert property (
		tick && div_sel == 2'h1 && $stable(div_sel) |-> ##1 s_gap8
	) else $error("count clock not system clock over 8");

	a_counter_inc: assert property (
		counter_run_enable && tick |=> free_run_counter_reg == $past(free_run_counter_reg) + 16'h0001
	) else $error("counter did not increment on count clock");

	a_counter_hold: assert property (
		!tick |=> $stable(free_run_counter_reg)
	) else $error("counter moved without count clock");

	a_cap_a_value: assert property (
		qual[0] |=> cap_reg[0] == $past(free_run_counter_reg) && status_reg[0]
	) else $error("capture a value or request wrong");

	a_cap_b_value: assert property (
		qual[1] |=> cap_reg[1] == $past(free_run_counter_reg) && status_reg[1]
	) else $error("capture b value or request wrong");

	a_cap_c_value: assert property (
		qual[2] |=> cap_reg[2] == $past(free_run_counter_reg) && status_reg[2]
	) else $error("capture c value or request wrong");

	a_cap_hold: assert property (
		!qual[0] |=> $stable(cap_reg[0])
	) else $error("capture a changed without edge");

	a_cap_b_hold: assert property (
		!qual[1] |=> $stable(cap_reg[1])
	) else $error("capture b changed without edge");

	a_cap_c_hold: assert property (
		!qual[2] |=> $stable(cap_reg[2])
	) else $error("capture c changed without edge");

	a_code_a_bad: assert property (
		edge_code[0] == EDGE_BAD |-> !qual[0]
	) else $error("prohibited code on a captured");

	a_code_b_bad: assert property (
		edge_code[1] == EDGE_BAD |-> !qual[1]
	) else $error("prohibited code on b captured");

	a_code_c_bad: assert property (
		edge_code[2] == EDGE_BAD |-> !qual[2]
	) else $error("prohibited code on c captured");

	a_code_c_fall: assert property (
		edge_code[2] == EDGE_FALL && qual[2] |-> fall[2] && !rise[2]
	) else $error("falling code on c took a rise");

	a_code_a_rise: assert property (
		edge_code[0] == EDGE_RISE && qual[0] |-> rise[0] && !fall[0]
	) else $error("rising code on a took a fall");

	a_code_b_both: assert property (
		edge_code[1] == EDGE_BOTH && (rise[1] || fall[1]) |-> qual[1]
	) else $error("both-edge code on b missed an edge");

	a_edge_on_tick: assert property (
		qual != '0 |-> tick && counter_run_enable
	) else $error("edge qualified off the count clock");

	a_irq_level: assert property (
		##1 irq_reg == |(status_reg & mask_reg)
	) else $error("interrupt output disagrees with status and mask");

	a_stop_no_edge: assert property (
		!counter_run_enable |-> qual == '0
	) else $error("edge accepted while stopped");

	// Longest lag is 127 cycles, one short of a period of the slowest count clock
	a_start_lag: assert property (
		$rose(counter_run_enable) |-> ##[3:127] (tick || !counter_run_enable)
	) else $error("count clock late after enable");

	a_status_sticky: assert property (
		status_reg[0] && !rd_status_done |=> status_reg[0]
	) else $error("status a dropped without a read");

	a_status_cause: assert property (
		!qual[0] |=> !$rose(status_reg[0])
	) else $error("status a set without an edge");

	a_mode_unused: assert property (
		(counter_mode_control_reg & ~(8'h01 << MODE_RUN_BIT)) == 8'h00
	) else $error("mode register holds an unused bit");

endmodule

// File: bench/frpc_pulse_src.sv
`timescale 1ns/1ns
module frpc_pulse_src (
	// Clock
	input wire logic pclk,
	// Capture pins
	output logic pin_a,
	output logic pin_b,
	output logic pin_c
);
	logic [2:0] lvl = 3'h0;

	assign {pin_c, pin_b, pin_a} = lvl;

	// Levels move just after a rising edge and then hold whole cycles
	task automatic drive(input int ch, input logic v, input int hold);
		@(posedge pclk);
		lvl[ch] <= v;
		repeat (hold) @(posedge pclk);
	endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ns
module testbench import frpc_pkg::*; ;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic pin_a;
	logic pin_b;
	logic pin_c;
	int err_count = 0;
	int cmp_count = 0;
	int seed = 32'h80ab1db6;
	int ratio[4] = '{DIV_RATIO_0, DIV_RATIO_1, DIV_RATIO_2, DIV_RATIO_3};
	logic [1:0] codes[4] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_BAD};
	logic [APB_AW-1:0] caps[3] = '{ADDR_CAP_A, ADDR_CAP_B, ADDR_CAP_C};
	logic [APB_AW-1:0] regs[5] = '{ADDR_COUNTER, ADDR_MODE, ADDR_CFG, ADDR_STATUS, ADDR_MASK};

	always #25 pclk = ~pclk;

	frpc_top i_frpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_a(pin_a), .capture_input_b(pin_b), .capture_input_c(pin_c), .irq(irq));
	frpc_pulse_src i_frpc_pulse_src (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("access cycles", n, 32'h1);
	endtask

	task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [APB_AW-1:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask

	// Configuration only ever changes with the counter stopped
	task automatic setup_run(input logic [7:0] cfg);
		wr(ADDR_MODE, 32'h0);
		wr(ADDR_CFG, {24'h0, cfg});
		wr(ADDR_MODE, 32'h4);
	endtask

	function automatic logic [2:0] hit(input logic [1:0] code, input logic rising, input int ch);
		logic h;
		h = (code == EDGE_BOTH) || (code == EDGE_RISE && rising) || (code == EDGE_FALL && !rising);
		return h ? 3'(1 << ch) : 3'h0;
	endfunction

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic e;
		logic [31:0] q;
		logic [31:0] c1;
		logic [31:0] c2;
		logic [2:0] exp;
		logic [2:0] msk;
		int w;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (regs[i]) begin
			rd(regs[i], q);
			check("reset value", q, 32'h0);
		end
		wr(ADDR_COUNTER, 32'h1234);
		rd(ADDR_COUNTER, q);
		check("counter read-only", q, 32'h0);
		wr(ADDR_MODE, 32'hFF);
		rd(ADDR_MODE, q);
		check("mode bits", q, 32'h4);
		apb(1'b0, '0, 32'h0, q, e);
		check("unmapped error", {31'h0, e}, 32'h1);
		$display("test registers done");
		for (int d = 0; d < 4; d++) begin
			setup_run(8'(d));
			rd(ADDR_COUNTER, c1);
			// Setup edges end up exactly five count periods apart
			repeat (5 * ratio[d] - 3) @(posedge pclk);
			rd(ADDR_COUNTER, c2);
			check("count rate", 32'(c2[15:0] - c1[15:0]), 32'h5);
		end
		$display("test prescaler done");
		for (int ch = 0; ch < 3; ch++) begin
			for (int j = 0; j < 4; j++) begin
				msk = 3'($random(seed));
				w = 5 + ($random(seed) & 7);
				wr(ADDR_MASK, {29'h0, msk});
				setup_run(8'({codes[j], 2'b00} << (2 * ch)));
				rd(ADDR_STATUS, q);
				// High time is w count periods: hold plus two reads plus the drive edge
				i_frpc_pulse_src.drive(ch, 1'b1, w * 4 - 7);
				exp = hit(codes[j], 1'b1, ch);
				check("irq on rise", {31'h0, irq}, {31'h0, |(exp & msk)});
				rd(ADDR_STATUS, q);
				check("status on rise", q, {29'h0, exp});
				rd(caps[ch], c1);
				i_frpc_pulse_src.drive(ch, 1'b0, 40);
				exp = hit(codes[j], 1'b0, ch);
				check("irq on fall", {31'h0, irq}, {31'h0, |(exp & msk)});
				rd(ADDR_STATUS, q);
				check("status on fall", q, {29'h0, exp});
				@(posedge pclk);
				check("irq cleared", {31'h0, irq}, 32'h0);
				rd(caps[ch], c2);
				if (codes[j] == EDGE_BOTH) begin
					check("pulse width", 32'(c2[15:0] - c1[15:0]), 32'(w));
				end
			end
		end
		$display("test edge modes done");
		setup_run(8'h04);
		rd(ADDR_STATUS, q);
		i_frpc_pulse_src.drive(0, 1'b1, 2);
		i_frpc_pulse_src.drive(0, 1'b0, 40);
		rd(ADDR_STATUS, q);
		check("short pulse", q, 32'h0);
		$display("test noise filter done");
		for (int lv = 1; lv >= 0; lv--) begin
			wr(ADDR_MODE, 32'h0);
			i_frpc_pulse_src.drive(0, 1'(lv), 4);
			rd(ADDR_STATUS, q);
			setup_run(8'h04);
			repeat (40) @(posedge pclk);
			rd(ADDR_STATUS, q);
			check("start level", q, 32'(lv));
		end
		$display("test start level done");
		wrap_up();
	end

	initial begin
		#(40000 * 50);
		err_count++;
		$display("unexpected timeout: expected finish, seen hang");
		wrap_up();
	end
endmodule
